// >>> common/oadc_pkg.sv
package oadc_pkg;

	// Converter geometry
	localparam int CODE_W = 13;
	localparam int CH_N = 8;
	localparam int PAIR_N = 4;
	localparam int STREAM_LEN = CH_N * CODE_W;
	localparam int IDX_W = 7;
	localparam int STEP_W = 4;
	localparam logic [STEP_W-1:0] SAR_TOP_STEP = 4'hc;
	localparam logic [CODE_W-1:0] CODE_SIGN = 13'h1000;
	localparam logic [CODE_W-1:0] CODE_ZERO = 13'h0000;

	// Register map, byte addresses on the 32-bit slave
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CONV_COUNT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_OVERRUN_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_LEVEL_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] REG_RESULT_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] REG_BLOCK_MASK = 8'he0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Throughput: least spacing between two convert starts
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAMPLE_RATE_KSPS = 1500;
	localparam int MIN_PERIOD_NS = (1000000 + SAMPLE_RATE_KSPS - 1) / SAMPLE_RATE_KSPS;
	localparam int MIN_PERIOD_CLKS = (MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SPACE_W = 8;

	// Register decode classes
	typedef enum logic [2:0] {
		OADC_SEL_NONE = 3'b000,
		OADC_SEL_STATUS = 3'b001,
		OADC_SEL_COUNT = 3'b010,
		OADC_SEL_OVERRUN = 3'b011,
		OADC_SEL_LEVEL = 3'b100,
		OADC_SEL_RESULT = 3'b101
	} oadc_sel_t;

	// Converter sequencer
	typedef enum logic [1:0] {
		OADC_IDLE = 2'b00,
		OADC_CONVERT = 2'b01,
		OADC_LOAD = 2'b10
	} oadc_state_t;

	// Status word as software sees it
	typedef struct packed {
		logic [25:0] zero;
		logic low_power;
		logic pair_mode;
		logic ddr;
		logic capture_clock_out_on;
		logic result_valid;
		logic busy;
	} oadc_status_t;

endpackage

// >>> verilog/oadc_readout.sv
`timescale 1ns/10ps
module oadc_readout
	import oadc_pkg::*;
(
	// System clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Converter pins
	input wire logic convert_strobe_n,
	input wire logic data_rate_select,
	input wire logic io_mode_select,
	input wire logic io_mode_float,
	input wire logic capture_clock_disable,
	// Serial link
	input wire logic serial_clock,
	output logic capture_clock_out,
	output logic [CH_N-1:0] lane_out,
	output logic [PAIR_N-1:0] pair_out,
	// Register slave, write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Register slave, read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Address to register class
	function automatic oadc_sel_t reg_class(input logic [ADDR_W-1:0] a);
		if (a == REG_STATUS)
			return OADC_SEL_STATUS;
		if (a == REG_CONV_COUNT)
			return OADC_SEL_COUNT;
		if (a == REG_OVERRUN_COUNT)
			return OADC_SEL_OVERRUN;
		if ((a & REG_BLOCK_MASK) == REG_LEVEL_BASE && a[1:0] == 2'b00)
			return OADC_SEL_LEVEL;
		if ((a & REG_BLOCK_MASK) == REG_RESULT_BASE && a[1:0] == 2'b00)
			return OADC_SEL_RESULT;
		return OADC_SEL_NONE;
	endfunction

	// Bit at stream position idx for a lane starting at channel first
	function automatic logic stream_bit(input logic [CH_N*CODE_W-1:0] bank,
		input int first, input logic [IDX_W-1:0] idx);
		int word;
		int ch;
		int bpos;
		word = int'(idx) / CODE_W;
		ch = (first + word) % CH_N;
		bpos = CODE_W - 1 - (int'(idx) % CODE_W);
		return bank[ch*CODE_W + bpos];
	endfunction

	// Sum of two stream counters, modulo the ring length
	function automatic logic [IDX_W-1:0] ring_sum(input logic [IDX_W-1:0] a,
		input logic [IDX_W-1:0] b);
		logic [IDX_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= (IDX_W+1)'(STREAM_LEN))
			s = s - (IDX_W+1)'(STREAM_LEN);
		return s[IDX_W-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] cnv_sync;
	logic [1:0] rate_sync;
	logic [1:0] mode_sync;
	logic [1:0] float_sync;
	logic [1:0] clkdis_sync;
	logic cnv_prev;
	wire logic cnv_fall = cnv_prev & ~cnv_sync[1];

	// Two flops per pin, only the second is read
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnv_sync <= 2'b11;
			rate_sync <= 2'b00;
			mode_sync <= 2'b00;
			float_sync <= 2'b00;
			clkdis_sync <= 2'b00;
			cnv_prev <= 1'b1;
		end
		else if (ce)
		begin
			cnv_sync <= {cnv_sync[0], convert_strobe_n};
			rate_sync <= {rate_sync[0], data_rate_select};
			mode_sync <= {mode_sync[0], io_mode_select};
			float_sync <= {float_sync[0], io_mode_float};
			clkdis_sync <= {clkdis_sync[0], capture_clock_disable};
			cnv_prev <= cnv_sync[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer

	oadc_state_t state;
	logic [STEP_W-1:0] step;
	logic [CH_N*CODE_W-1:0] level_reg;
	logic [CH_N*CODE_W-1:0] held;
	logic [CH_N*CODE_W-1:0] trial;
	logic [CH_N*CODE_W-1:0] bank;
	logic hold_clear;
	logic result_valid;
	logic cfg_ddr;
	logic cfg_pair;
	logic cfg_low_power;
	logic capture_clock_out_on;
	logic [31:0] conv_count;
	logic [31:0] overrun_count;
	logic [SPACE_W-1:0] space;
	wire logic too_soon = (space < SPACE_W'(MIN_PERIOD_CLKS));
	wire logic last_step = (step == STEP_W'(0));
	logic [CH_N*CODE_W-1:0] next_trial;

	// Binary search per channel in offset-binary, top bit first
	genvar gc;
	generate
		for (gc = 0; gc < CH_N; gc++)
		begin : g_sar
			wire logic [CODE_W-1:0] target = held[gc*CODE_W +: CODE_W] ^ CODE_SIGN;
			wire logic [CODE_W-1:0] cur = trial[gc*CODE_W +: CODE_W];
			wire logic [CODE_W-1:0] weight = CODE_W'(1) << step;
			// Trial already carries the weight under test; drop it on overshoot
			wire logic [CODE_W-1:0] test = cur & ~weight;
			wire logic [CODE_W-1:0] lower = CODE_W'(1) << (step - STEP_W'(1));
			// Keep the weight if it does not overshoot, try the next one
			wire logic [CODE_W-1:0] kept = (cur <= target) ? cur : test;
			assign next_trial[gc*CODE_W +: CODE_W] = last_step ? kept : (kept | lower);
		end
	endgenerate

	// Sequencer: sample, search, load the output bank
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= OADC_IDLE;
			step <= SAR_TOP_STEP;
			held <= '0;
			trial <= '0;
			bank <= '0;
			hold_clear <= 1'b1;
			result_valid <= 1'b0;
			cfg_ddr <= 1'b0;
			cfg_pair <= 1'b0;
			cfg_low_power <= 1'b0;
			capture_clock_out_on <= 1'b0;
			conv_count <= '0;
			overrun_count <= '0;
			space <= '0;
		end
		else if (ce)
		begin
			if (!too_soon)
				space <= space;
			else
				space <= space + SPACE_W'(1);
			unique case (state)
				OADC_IDLE:
				begin
					if (cnv_fall)
					begin
						held <= level_reg;
						trial <= {CH_N{CODE_SIGN}};
						step <= SAR_TOP_STEP;
						hold_clear <= 1'b1;
						space <= '0;
						conv_count <= conv_count + 32'h00000001;
						if (too_soon && result_valid)
							overrun_count <= overrun_count + 32'h00000001;
						state <= OADC_CONVERT;
					end
				end
				OADC_CONVERT:
				begin
					trial <= next_trial;
					step <= step - STEP_W'(1);
					if (last_step)
						state <= OADC_LOAD;
				end
				OADC_LOAD:
				begin
					// Back to two's complement; this conversion's own codes
					for (int c = 0; c < CH_N; c++)
						bank[c*CODE_W +: CODE_W] <= trial[c*CODE_W +: CODE_W] ^ CODE_SIGN;
					cfg_ddr <= rate_sync[1];
					cfg_pair <= mode_sync[1] | float_sync[1];
					cfg_low_power <= float_sync[1];
					capture_clock_out_on <= ~clkdis_sync[1];
					result_valid <= 1'b1;
					hold_clear <= 1'b0;
					state <= OADC_IDLE;
				end
				default:
					state <= OADC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial link, on the host's serial clock

	logic [IDX_W-1:0] fall_cnt;
	logic [IDX_W-1:0] rise_cnt;
	logic [CH_N-1:0] lane_fall;
	logic [CH_N-1:0] lane_rise;
	logic [PAIR_N-1:0] pair_fall;
	logic [PAIR_N-1:0] pair_rise;
	wire logic [IDX_W-1:0] fall_pos = cfg_ddr ? ring_sum(fall_cnt, rise_cnt) : fall_cnt;
	wire logic [IDX_W-1:0] rise_pos = ring_sum(fall_cnt, rise_cnt);
	wire logic show_rise = cfg_ddr & serial_clock;
	logic [CH_N-1:0] next_lane_fall;
	logic [CH_N-1:0] next_lane_rise;
	logic [PAIR_N-1:0] next_pair_fall;
	logic [PAIR_N-1:0] next_pair_rise;

	// Lane streams start at their own channel and run round the ring
	genvar gl;
	generate
		for (gl = 0; gl < CH_N; gl++)
		begin : g_lane
			assign next_lane_fall[gl] = ~cfg_pair & stream_bit(bank, gl, fall_pos);
			assign next_lane_rise[gl] = ~cfg_pair & stream_bit(bank, gl, rise_pos);
		end
		for (gl = 0; gl < PAIR_N; gl++)
		begin : g_pair
			// Pair carries even then odd channel and onward
			assign next_pair_fall[gl] = cfg_pair & stream_bit(bank, 2*gl, fall_pos);
			assign next_pair_rise[gl] = cfg_pair & stream_bit(bank, 2*gl, rise_pos);
		end
	endgenerate

	// Falling edges always shift; counters cleared while a conversion runs
	always_ff @(negedge serial_clock or posedge hold_clear)
	begin
		if (hold_clear)
		begin
			fall_cnt <= '0;
			lane_fall <= '0;
			pair_fall <= '0;
		end
		else
		begin
			lane_fall <= next_lane_fall;
			pair_fall <= next_pair_fall;
			fall_cnt <= (fall_cnt == IDX_W'(STREAM_LEN - 1)) ? '0 : fall_cnt + IDX_W'(1);
		end
	end

	// Rising edges shift only at double rate
	always_ff @(posedge serial_clock or posedge hold_clear)
	begin
		if (hold_clear)
		begin
			rise_cnt <= '0;
			lane_rise <= '0;
			pair_rise <= '0;
		end
		else if (cfg_ddr)
		begin
			lane_rise <= next_lane_rise;
			pair_rise <= next_pair_rise;
			rise_cnt <= (rise_cnt == IDX_W'(STREAM_LEN - 1)) ? '0 : rise_cnt + IDX_W'(1);
		end
	end

	// Select the flop of the last shifting edge; echo clock when enabled
	assign lane_out = show_rise ? lane_rise : lane_fall;
	assign pair_out = show_rise ? pair_rise : pair_fall;
	assign capture_clock_out = serial_clock & capture_clock_out_on;

	////////////////////////////////////////////////////////////////////////
	// Register slave

	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire oadc_sel_t wr_sel = reg_class(aw_addr);
	wire oadc_sel_t rd_sel = reg_class(s_axi_araddr);
	wire logic [2:0] wr_ch = aw_addr[4:2];
	wire logic [2:0] rd_ch = s_axi_araddr[4:2];
	wire logic do_write = aw_held & w_held & ~s_axi_bvalid;
	wire logic do_read = s_axi_arvalid & s_axi_arready;
	oadc_status_t status;
	wire logic [CODE_W-1:0] wr_old = level_reg[wr_ch*CODE_W +: CODE_W];
	wire logic [15:0] wr_merge = {w_strb[1] ? w_data[15:8] : {3'b000, wr_old[12:8]},
		w_strb[0] ? w_data[7:0] : wr_old[7:0]};
	wire logic [CODE_W-1:0] rd_level = level_reg[rd_ch*CODE_W +: CODE_W];
	wire logic [CODE_W-1:0] rd_result = bank[rd_ch*CODE_W +: CODE_W];

	// Status word assembly
	assign status = '{zero: '0, low_power: cfg_low_power, pair_mode: cfg_pair,
		ddr: cfg_ddr, capture_clock_out_on: capture_clock_out_on, result_valid: result_valid,
		busy: (state != OADC_IDLE)};

	// Address and data taken in either order, answer after both
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			level_reg <= '0;
		end
		else if (ce)
		begin
			s_axi_awready <= ~aw_held & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_held & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == OADC_SEL_LEVEL) ? RESP_OKAY : RESP_SLVERR;
				if (wr_sel == OADC_SEL_LEVEL)
					level_reg[wr_ch*CODE_W +: CODE_W] <= wr_merge[CODE_W-1:0];
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel, one read at a time
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_arready <= ~s_axi_rvalid & ~do_read;
			if (do_read)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= (rd_sel == OADC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
				unique case (rd_sel)
					OADC_SEL_STATUS: s_axi_rdata <= status;
					OADC_SEL_COUNT: s_axi_rdata <= conv_count;
					OADC_SEL_OVERRUN: s_axi_rdata <= overrun_count;
					OADC_SEL_LEVEL: s_axi_rdata <= {19'h00000, rd_level};
					OADC_SEL_RESULT: s_axi_rdata <= {{19{rd_result[CODE_W-1]}}, rd_result};
					OADC_SEL_NONE: s_axi_rdata <= '0;
					default: s_axi_rdata <= '0;
				endcase
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // oadc_readout

// >>> tb/oadc_readout_asserts.sv
`timescale 1ns/10ps
module oadc_readout_asserts
	import oadc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Converter pins
	input wire logic convert_strobe_n,
	input wire logic capture_clock_disable,
	input wire logic serial_clock,
	input wire logic capture_clock_out,
	input wire logic [CH_N-1:0] lane_out,
	input wire logic [PAIR_N-1:0] pair_out,
	// Register slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Handshake takes on the register slave
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;

	////////////////////////////////////////////////////////////////////////////////
	a_echo_gate: assert property (capture_clock_out |-> serial_clock)
		else $error("capture clock high while serial clock low");
	a_echo_off: assert property (capture_clock_disable [*4] |-> !capture_clock_out)
		else $error("capture clock runs while disabled");
	a_conv_clear: assert property ($fell(convert_strobe_n) |-> ##[3:6]
		(lane_out == '0 && pair_out == '0))
		else $error("outputs not cleared after convert start");
	a_bresp_soon: assert property (aw_take && w_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_rvalid_next: assert property (ar_take |=> s_axi_rvalid)
		else $error("read data late");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address accepted during response");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during read data");
	a_status_ro: assert property (aw_take && w_take && s_axi_awaddr == REG_STATUS
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
		else $error("status write not refused");
	a_unmapped_read: assert property (ar_take && s_axi_araddr == 8'h10
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
endmodule // oadc_readout_asserts

bind oadc_readout oadc_readout_asserts u_asserts (.clk, .rst, .convert_strobe_n,
	.capture_clock_disable, .serial_clock, .capture_clock_out, .lane_out, .pair_out,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// >>> tb/oadc_host_model.sv
`timescale 1ns/10ps
module oadc_host_model
	import oadc_pkg::*;
(
	// Host side pins
	output logic convert_strobe_n,
	output logic serial_clock,
	input wire logic ddr,
	// Returned link
	input wire logic capture_clock_out,
	input wire logic [CH_N-1:0] lane_out,
	input wire logic [PAIR_N-1:0] pair_out
);
	logic [CH_N-1:0] lane_bits [$];
	logic [PAIR_N-1:0] pair_bits [$];

	initial
	begin
		convert_strobe_n = 1'b1;
		serial_clock = 1'b0;
	end

	// Acquire, then start one conversion; clock stays still meanwhile
	task automatic convert();
		convert_strobe_n = 1'b1;
		#403; // Fall lands off the system clock edge
		convert_strobe_n = 1'b0;
		#600;
		convert_strobe_n = 1'b1;
	endtask

	// Give n shifting edges at 30 ns period, clock idles low after except at double rate with odd n
	task automatic read_edges(input int n);
		lane_bits.delete();
		pair_bits.delete();
		#3;
		for (int k = 0; k < n; k++)
		begin
			if (ddr)
				#15 serial_clock = ~serial_clock;
			else
			begin
				#15 serial_clock = 1'b1;
				#15 serial_clock = 1'b0;
			end
		end
		#20;
	endtask

	// Latch each bit mid-cell, timed by the echoed capture clock
	always @(capture_clock_out)
		if (!capture_clock_out || ddr)
		begin
			#7;
			lane_bits.push_back(lane_out);
			pair_bits.push_back(pair_out);
		end
endmodule // oadc_host_model

// >>> tb/octal_adc_serial_readout_bench.sv
`timescale 1ns/10ps
`define CHECK(name, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("Error %s expected %h seen %h", name, exp, got); \
		end \
	end
module octal_adc_serial_readout_bench
	import oadc_pkg::*;
;
	logic clk, rst, ce, data_rate_select, io_mode_select, io_mode_float;
	logic capture_clock_disable, serial_clock, convert_strobe_n, capture_clock_out;
	logic [CH_N-1:0] lane_out;
	logic [PAIR_N-1:0] pair_out;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	localparam logic [CODE_W-1:0] LEVELS [16] = '{
		13'h1000, 13'h0fff, 13'h1800, 13'h07ff, 13'h0000, 13'h0001, 13'h1fff, 13'h0a5a,
		13'h0123, 13'h1234, 13'h0f0f, 13'h10f0, 13'h0555, 13'h1aaa, 13'h0800, 13'h17ff};

	oadc_readout u_dut (.clk, .rst, .ce, .convert_strobe_n, .data_rate_select,
		.io_mode_select, .io_mode_float, .capture_clock_disable, .serial_clock,
		.capture_clock_out, .lane_out, .pair_out, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	oadc_host_model u_host (.convert_strobe_n, .serial_clock, .ddr(data_rate_select),
		.capture_clock_out, .lane_out, .pair_out);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			stop_test();
		end
	end

	// Register write, both channels offered together
	task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
		logic ta, tw;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		while (!(ta && tw) && (s_axi_awvalid || s_axi_wvalid));
		do @(negedge clk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask

	// Register read
	task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask

	// Load levels, convert, check results, status and the serial stream
	task automatic run(input int set, input logic m, f, dr, dis, input int n);
		int ch;
		int units;
		logic [CH_N-1:0] side;
		for (int c = 0; c < CH_N; c++)
		begin
			axi_write(REG_LEVEL_BASE + 8'(4 * c), {19'h00000, LEVELS[set * 8 + c]}, r);
			`CHECK("level resp", RESP_OKAY, r)
		end
		@(posedge clk);
		io_mode_select <= m;
		io_mode_float <= f;
		data_rate_select <= dr;
		capture_clock_disable <= dis;
		u_host.convert();
		for (int c = 0; c < CH_N; c++)
		begin
			axi_read(REG_RESULT_BASE + 8'(4 * c), d, r);
			`CHECK("result", {{19{LEVELS[set * 8 + c][12]}}, LEVELS[set * 8 + c]}, d)
		end
		axi_read(REG_STATUS, d, r);
		`CHECK("status", {f, m | f, dr, !dis, 1'b1, 1'b0}, d[5:0])
		u_host.read_edges(n);
		`CHECK("bit count", dis ? 0 : n, u_host.lane_bits.size())
		units = (m | f) ? PAIR_N : CH_N;
		for (int i = 0; i < u_host.lane_bits.size(); i++)
		begin
			side = (m | f) ? u_host.lane_bits[i] : {4'h0, u_host.pair_bits[i]};
			`CHECK("unused outputs", 8'h00, side)
			for (int u = 0; u < units; u++)
			begin
				ch = (((m | f) ? 2 * u : u) + i / CODE_W) % CH_N;
				side = (m | f) ? {4'h0, u_host.pair_bits[i]} : u_host.lane_bits[i];
				`CHECK("serial bit", LEVELS[set * 8 + ch][CODE_W - 1 - i % CODE_W], side[u])
			end
		end
	endtask

	// Verdict and end of run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{clk, ce, rst} = 3'b011;
		{data_rate_select, io_mode_select, io_mode_float, capture_clock_disable} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		axi_read(REG_STATUS, d, r);
		`CHECK("reset status", 3'h0, d[2:0])
		axi_read(8'h10, d, r);
		`CHECK("unmapped resp", RESP_SLVERR, r)
		axi_write(REG_STATUS, 32'h0000003f, r);
		`CHECK("status write resp", RESP_SLVERR, r)
		run(0, 1'b0, 1'b0, 1'b0, 1'b0, 117);
		run(1, 1'b1, 1'b0, 1'b1, 1'b0, 104);
		run(0, 1'b0, 1'b1, 1'b0, 1'b0, 32);
		run(1, 1'b0, 1'b0, 1'b1, 1'b1, 26);
		axi_read(REG_CONV_COUNT, d, r);
		`CHECK("conversions", 32'h00000004, d)
		axi_read(REG_OVERRUN_COUNT, d, r);
		`CHECK("overruns", 32'h00000000, d)
		axi_read(REG_LEVEL_BASE, d, r);
		`CHECK("level readback", {19'h0, LEVELS[8]}, d)
		stop_test();
	end
endmodule // octal_adc_serial_readout_bench
